// >>> ipf_consts.vh
`ifndef IPF_CONSTS_VH
`define IPF_CONSTS_VH

// Register byte offsets
`define IPF_OFF_CTRL      8'h00
`define IPF_OFF_NHNUM     8'h04
`define IPF_OFF_STAT      8'h08
`define IPF_OFF_PASSCNT   8'h0C
`define IPF_OFF_BLKCNT    8'h10
`define IPF_OFF_SRCADDR   8'h20
`define IPF_OFF_SRCMASK   8'h30
`define IPF_OFF_DSTADDR   8'h40
`define IPF_OFF_DSTMASK   8'h50

// Control fields
`define IPF_CTRL_SRC_EQ   0
`define IPF_CTRL_DST_EQ   1
`define IPF_CTRL_NH_EQ    2
`define IPF_CTRL_NHSEL_LO 4
`define IPF_CTRL_NHSEL_HI 5

// Next header selection codes
`define IPF_NHSEL_NUM     2'h0
`define IPF_NHSEL_UDP     2'h1
`define IPF_NHSEL_TCP     2'h2
`define IPF_NHSEL_ICMP    2'h3

// Protocol identifiers
`define IPF_PROTO_UDP     8'h11
`define IPF_PROTO_TCP     8'h06
`define IPF_PROTO_ICMP6   8'h3A

// Header byte positions
`define IPF_HDR_NH_BYTE   6
`define IPF_HDR_SRC_BYTE  8
`define IPF_HDR_DST_BYTE  24
`define IPF_HDR_LEN       40

// Reset values and response codes
`define IPF_RST_WORD      32'h00000000
`define IPF_RESP_OKAY     2'h0
`define IPF_RESP_SLVERR   2'h2

`endif

// >>> ipf_filter.v
// How it works
// [RL1] Source criterion on ignore leaves source address out of the decision.
// [RL2] Packet passes only if no enabled criterion blocks it.
// [RL3] Source equal-to passes only packets matching masked configured address.
// [RL4] Holds a 128-bit configurable source address, eight 16-bit groups.
// [RL5] Source mask is ANDed with the packet source address before compare.
// [RL6] Destination criterion has same ignore and equal-to behaviour.
// [RL7] Holds a 128-bit configurable destination address.
// [RL8] Destination mask is ANDed before destination comparison.
// [RL9] Next header 8-bit criterion with ignore and equal-to settings.
// [RL10] Next header value selectable as UDP, TCP, ICMP or numeric.
// [RL11] Named selections map to 17, 6 and 58.
// [RL12] Numeric next header value used only when selection is numeric.
// [RL13] Fields taken from fixed header positions; one decision per packet.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module ipf_filter (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    input  wire [7:0]  pkt_data,
    input  wire        pkt_valid,
    input  wire        pkt_last,
    output reg         dec_valid,
    output reg         dec_pass
);
`include "ipf_consts.vh"

    reg  [31:0]  ctrl_q;
    reg  [7:0]   nhnum_q;
    reg  [31:0]  src_cfg_q [0:3];
    reg  [31:0]  src_msk_q [0:3];
    reg  [31:0]  dst_cfg_q [0:3];
    reg  [31:0]  dst_msk_q [0:3];
    reg  [31:0]  pass_cnt_q;
    reg  [31:0]  blk_cnt_q;
    reg          last_pass_q;
    reg          seen_q;
    reg          aw_got_q;
    reg          w_got_q;
    reg  [7:0]   aw_addr_q;
    reg  [31:0]  w_data_q;
    reg  [3:0]   w_strb_q;
    reg  [127:0] hsrc_q;
    reg  [127:0] hdst_q;
    reg  [7:0]   hnh_q;
    reg  [5:0]   bcnt_q;
    wire [127:0] pkt_dst_now;
    wire [127:0] src_cfg;
    wire [127:0] src_msk;
    wire [127:0] dst_cfg;
    wire [127:0] dst_msk;
    wire         match_pass;
    wire         wr_go;
    integer      i;

    // Word index inside a four-word 128-bit block; word 0 holds group A:B
    function [1:0] word_idx;
        input [7:0] a;
        begin
            word_idx = a[3:2];
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (st[k]) merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pack
            assign src_cfg[127-32*g -: 32] = src_cfg_q[g]; // RL4
            assign src_msk[127-32*g -: 32] = src_msk_q[g];
            assign dst_cfg[127-32*g -: 32] = dst_cfg_q[g]; // RL7
            assign dst_msk[127-32*g -: 32] = dst_msk_q[g];
        end
    endgenerate

    // Write channel: address and data taken in either order
    assign awready = !aw_got_q && !bvalid;
    assign wready  = !w_got_q && !bvalid;
    assign wr_go   = aw_got_q && w_got_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= `IPF_RST_WORD;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `IPF_RESP_OKAY;
            ctrl_q    <= `IPF_RST_WORD;
            nhnum_q   <= 8'h00;
            for (i = 0; i < 4; i = i + 1) begin
                src_cfg_q[i] <= `IPF_RST_WORD;
                src_msk_q[i] <= `IPF_RST_WORD;
                dst_cfg_q[i] <= `IPF_RST_WORD;
                dst_msk_q[i] <= `IPF_RST_WORD;
            end
        end else begin
            if (awvalid && awready) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_q  <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= `IPF_RESP_OKAY;
                case (aw_addr_q[7:4])
                    4'h0: begin
                        if (aw_addr_q == `IPF_OFF_CTRL) begin
                            ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h00000037;
                        end else if (aw_addr_q == `IPF_OFF_NHNUM) begin
                            if (w_strb_q[0]) nhnum_q <= w_data_q[7:0];
                        end else if (aw_addr_q != `IPF_OFF_STAT &&
                                     aw_addr_q != `IPF_OFF_PASSCNT) begin
                            bresp <= `IPF_RESP_SLVERR;
                        end
                    end
                    4'h1: begin
                        if (aw_addr_q != `IPF_OFF_BLKCNT) bresp <= `IPF_RESP_SLVERR;
                    end
                    4'h2: src_cfg_q[word_idx(aw_addr_q)] <=
                        merge(src_cfg_q[word_idx(aw_addr_q)], w_data_q, w_strb_q); // RL4
                    4'h3: src_msk_q[word_idx(aw_addr_q)] <=
                        merge(src_msk_q[word_idx(aw_addr_q)], w_data_q, w_strb_q);
                    4'h4: dst_cfg_q[word_idx(aw_addr_q)] <=
                        merge(dst_cfg_q[word_idx(aw_addr_q)], w_data_q, w_strb_q); // RL7
                    4'h5: dst_msk_q[word_idx(aw_addr_q)] <=
                        merge(dst_msk_q[word_idx(aw_addr_q)], w_data_q, w_strb_q);
                    default: bresp <= `IPF_RESP_SLVERR;
                endcase
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after address taken
    assign arready = !rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= `IPF_RST_WORD;
            rresp  <= `IPF_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= `IPF_RESP_OKAY;
            rdata  <= `IPF_RST_WORD;
            case (araddr[7:4])
                4'h0: begin
                    if (araddr == `IPF_OFF_CTRL) rdata <= ctrl_q;
                    else if (araddr == `IPF_OFF_NHNUM) rdata <= {24'h000000, nhnum_q};
                    else if (araddr == `IPF_OFF_STAT) rdata <= {30'h0, seen_q, last_pass_q};
                    else if (araddr == `IPF_OFF_PASSCNT) rdata <= pass_cnt_q;
                    else rresp <= `IPF_RESP_SLVERR;
                end
                4'h1: begin
                    if (araddr == `IPF_OFF_BLKCNT) rdata <= blk_cnt_q;
                    else rresp <= `IPF_RESP_SLVERR;
                end
                4'h2: rdata <= src_cfg_q[word_idx(araddr)];
                4'h3: rdata <= src_msk_q[word_idx(araddr)];
                4'h4: rdata <= dst_cfg_q[word_idx(araddr)];
                4'h5: rdata <= dst_msk_q[word_idx(araddr)];
                default: rresp <= `IPF_RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Header capture from the byte stream; byte 0 is the version nibble
    always @(posedge aclk) begin
        if (!aresetn) begin
            bcnt_q  <= 6'h00;
            hsrc_q  <= 128'h0;
            hdst_q  <= 128'h0;
            hnh_q   <= 8'h00;
        end else if (pkt_valid) begin
            if (bcnt_q < `IPF_HDR_LEN) begin
                if (bcnt_q == `IPF_HDR_NH_BYTE) hnh_q <= pkt_data; // RL13
                if (bcnt_q >= `IPF_HDR_SRC_BYTE && bcnt_q < `IPF_HDR_DST_BYTE)
                    hsrc_q <= {hsrc_q[119:0], pkt_data}; // RL13
                if (bcnt_q >= `IPF_HDR_DST_BYTE)
                    hdst_q <= {hdst_q[119:0], pkt_data}; // RL13
            end
            if (pkt_last) begin
                bcnt_q  <= 6'h00;
            end else if (bcnt_q < `IPF_HDR_LEN) begin
                bcnt_q <= bcnt_q + 6'h01;
            end
        end
    end

    // Last destination byte is still on the bus when a 40-byte packet ends
    assign pkt_dst_now = (bcnt_q == `IPF_HDR_LEN - 1) ? {hdst_q[119:0], pkt_data} : hdst_q;

    ipf_match u_match (
        .src_eq   (ctrl_q[`IPF_CTRL_SRC_EQ]),
        .dst_eq   (ctrl_q[`IPF_CTRL_DST_EQ]),
        .nh_eq    (ctrl_q[`IPF_CTRL_NH_EQ]),
        .nh_sel   (ctrl_q[`IPF_CTRL_NHSEL_HI:`IPF_CTRL_NHSEL_LO]),
        .nh_num   (nhnum_q),
        .src_cfg  (src_cfg),
        .src_mask (src_msk),
        .dst_cfg  (dst_cfg),
        .dst_mask (dst_msk),
        .pkt_src  (hsrc_q),
        .pkt_dst  (pkt_dst_now),
        .pkt_nh   (hnh_q),
        .pass     (match_pass)
    );

    // Decision on the last packet byte, not at header end; truncated packets are blocked
    wire hdr_done = (bcnt_q >= `IPF_HDR_LEN - 1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            dec_valid   <= 1'b0;
            dec_pass    <= 1'b0;
            last_pass_q <= 1'b0;
            seen_q      <= 1'b0;
            pass_cnt_q  <= `IPF_RST_WORD;
            blk_cnt_q   <= `IPF_RST_WORD;
        end else begin
            dec_valid <= 1'b0;
            if (pkt_valid && pkt_last) begin
                dec_valid   <= 1'b1; // RL13
                dec_pass    <= hdr_done & match_pass; // RL2
                last_pass_q <= hdr_done & match_pass;
                seen_q      <= 1'b1;
                if (hdr_done & match_pass) pass_cnt_q <= pass_cnt_q + 32'h1;
                else blk_cnt_q <= blk_cnt_q + 32'h1;
            end
        end
    end
endmodule

// >>> ipf_filter_chk.sv
`timescale 1ns/1ns
module ipf_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        awvalid,
    input wire        awready,
    input wire        wvalid,
    input wire        wready,
    input wire        bvalid,
    input wire        arvalid,
    input wire        arready,
    input wire [31:0] rdata,
    input wire        rvalid,
    input wire        rready,
    input wire        pkt_valid,
    input wire        pkt_last,
    input wire        dec_valid,
    input wire        dec_pass
);
    reg  [5:0] n_q;
    wire       eop = pkt_valid && pkt_last;
    wire [5:0] n_d = eop ? 6'h00 : (pkt_valid && n_q != 6'h3F) ? n_q + 6'h01 : n_q;
    always @(posedge aclk) begin
        n_q <= aresetn ? n_d : 6'h00;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
    sequence s_bup; ##[1:2] bvalid; endsequence
    property p_dec; eop |=> dec_valid; endproperty
    a_dec: assert property (p_dec) else $error("no decision after last byte");
    property p_nodec; !eop |=> !dec_valid; endproperty
    a_nodec: assert property (p_nodec) else $error("stray decision");
    // Length is counted here, header under 40 bytes must block
    property p_short; eop && n_q < 6'h27 |=> !dec_pass; endproperty
    a_short: assert property (p_short) else $error("short packet passed");
    property p_hold; !dec_valid |-> $stable(dec_pass); endproperty
    a_hold: assert property (p_hold) else $error("decision moved");
    property p_wref; bvalid |-> !awready && !wready; endproperty
    a_wref: assert property (p_wref) else $error("write taken during response");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rans; arvalid && arready |=> rvalid; endproperty
    a_rans: assert property (p_rans) else $error("late read answer");
    property p_bans; s_wtake |-> s_bup; endproperty
    a_bans: assert property (p_bans) else $error("late write answer");
endmodule
bind ipf_filter ipf_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .arvalid, .arready, .rdata, .rvalid, .rready, .pkt_valid, .pkt_last,
    .dec_valid, .dec_pass);

// >>> ipf_match.v
`timescale 1ns/1ns
module ipf_match (
    input  wire         src_eq,
    input  wire         dst_eq,
    input  wire         nh_eq,
    input  wire [1:0]   nh_sel,
    input  wire [7:0]   nh_num,
    input  wire [127:0] src_cfg,
    input  wire [127:0] src_mask,
    input  wire [127:0] dst_cfg,
    input  wire [127:0] dst_mask,
    input  wire [127:0] pkt_src,
    input  wire [127:0] pkt_dst,
    input  wire [7:0]   pkt_nh,
    output wire         pass
);
`include "ipf_consts.vh"

    function match_masked;
        input [127:0] a;
        input [127:0] b;
        input [127:0] m;
        begin
            match_masked = ((a & m) == (b & m));
        end
    endfunction

    reg  [7:0] nh_want;
    wire       src_ok;
    wire       dst_ok;
    wire       nh_ok;

    always @* begin
        case (nh_sel)
            `IPF_NHSEL_UDP:  nh_want = `IPF_PROTO_UDP; // RL11
            `IPF_NHSEL_TCP:  nh_want = `IPF_PROTO_TCP; // RL11
            `IPF_NHSEL_ICMP: nh_want = `IPF_PROTO_ICMP6; // RL11
            default:         nh_want = nh_num; // RL12
        endcase
    end

    // Mask applies to both sides so unmasked config bits never matter
    assign src_ok = !src_eq || match_masked(pkt_src, src_cfg, src_mask); // RL1 RL3 RL5
    assign dst_ok = !dst_eq || match_masked(pkt_dst, dst_cfg, dst_mask); // RL6 RL8
    assign nh_ok  = !nh_eq || (pkt_nh == nh_want); // RL9 RL10
    assign pass   = src_ok & dst_ok & nh_ok; // RL2
endmodule

// >>> ipf_pkt_src.sv
`timescale 1ns/1ns
module ipf_pkt_src (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         go,
    input  wire [6:0]   len,
    input  wire [7:0]   nh,
    input  wire [127:0] src,
    input  wire [127:0] dst,
    output reg  [7:0]   pkt_data,
    output reg          pkt_valid,
    output reg          pkt_last
);
    reg [6:0] i_q;
    reg       act_q;
    function [7:0] hb(input [6:0] i);
        begin
            if (i == 7'h06) hb = nh;
            else if (i >= 7'h08 && i < 7'h18) hb = src[8 * (23 - i) +: 8];
            else if (i >= 7'h18 && i < 7'h28) hb = dst[8 * (39 - i) +: 8];
            else hb = {1'b0, i} ^ 8'h60;
        end
    endfunction
    always @(posedge aclk) begin
        if (!aresetn) begin
            act_q <= 1'b0;
            i_q <= 7'h00;
            pkt_valid <= 1'b0;
            pkt_last <= 1'b0;
            pkt_data <= 8'h00;
        end else begin
            pkt_valid <= act_q;
            pkt_last <= act_q && i_q == len - 7'h01;
            // Idle bus toggles so a stale byte is never mistaken for data
            pkt_data <= act_q ? hb(i_q) : ~pkt_data;
            if (go) begin
                act_q <= 1'b1;
                i_q <= 7'h00;
            end else if (act_q) begin
                i_q <= i_q + 7'h01;
                act_q <= i_q != len - 7'h01;
            end
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
`include "ipf_consts.vh"
module tb_top;
    reg          aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [7:0]   awaddr = 8'h00, araddr = 8'h00, nh = 8'h00;
    reg  [31:0]  wdata = 32'h0;
    reg  [3:0]   wstrb = 4'hF;
    reg  [6:0]   len = 7'h28;
    reg  [127:0] src = 128'h0, dst = 128'h0;
    wire         awready, wready, bvalid, arready, rvalid, pkt_valid, pkt_last;
    wire         dec_valid, dec_pass;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   pkt_data;
    integer      num_errors = 0, check_count = 0, ep = 0, eb = 0, cyc = 0, k;
    localparam [127:0] sa = 128'h20010DB8_00000000_00000000_00000001;
    localparam [127:0] da = 128'hFE800000_00000000_12345678_9ABCDEF0;
    localparam [127:0] mk = 128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFF0000;
    localparam [127:0] hi = {64'h1, 64'h0};
    localparam [23:0]  ids = {8'h3A, 8'h06, 8'h11};
    always #10 aclk = ~aclk;
    ipf_filter dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pkt_data, .pkt_valid, .pkt_last, .dec_valid, .dec_pass);
    ipf_pkt_src pm (.aclk, .aresetn, .go, .len, .nh, .src, .dst, .pkt_data, .pkt_valid,
        .pkt_last);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            @(posedge aclk);
            while (awvalid || wvalid) begin
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                @(posedge aclk);
            end
            while (!bvalid) @(posedge aclk);
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
        end
    endtask
    task wr4(input [7:0] b, input [127:0] v);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) wr(b + {i[5:0], 2'h0}, v[127 - 32 * i -: 32], 2'h0);
        end
    endtask
    task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            @(posedge aclk);
            while (!arready) @(posedge aclk);
            arvalid <= 1'b0;
            while (!rvalid) @(posedge aclk);
            // Late rready leaves the answer standing a cycle
            rready <= 1'b1;
            @(posedge aclk);
            rready <= 1'b0;
            chk(rdata, ed);
            chk({30'h0, rresp}, {30'h0, er});
        end
    endtask
    task pk(input [7:0] n, input [127:0] s, input [127:0] d, input [6:0] l, input e);
        begin
            @(posedge aclk);
            nh <= n;
            src <= s;
            dst <= d;
            len <= l;
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            while (!dec_valid) @(posedge aclk);
            chk({31'h0, dec_pass}, {31'h0, e});
            if (e) ep = ep + 1;
            else eb = eb + 1;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 12000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IPF_OFF_CTRL, 32'h0, `IPF_RESP_OKAY);
        pk(8'h3B, ~sa, da, 7'h28, 1'b1);
        pk(8'h3B, sa, da, 7'h27, 1'b0);
        $display("T1 done");
        wr4(`IPF_OFF_SRCADDR, sa);
        wr4(`IPF_OFF_SRCMASK, mk);
        wr(`IPF_OFF_CTRL, 32'h1, `IPF_RESP_OKAY);
        rd(`IPF_OFF_SRCADDR, 32'h20010DB8, `IPF_RESP_OKAY);
        pk(8'h3B, sa ^ 128'h1, da, 7'h28, 1'b1);
        pk(8'h3B, sa ^ hi, da, 7'h28, 1'b0);
        wr4(`IPF_OFF_DSTADDR, da);
        wr4(`IPF_OFF_DSTMASK, mk);
        wr(`IPF_OFF_CTRL, 32'h2, `IPF_RESP_OKAY);
        pk(8'h3B, sa ^ hi, da ^ 128'hFFFF, 7'h28, 1'b1);
        pk(8'h3B, sa, da ^ hi, 7'h28, 1'b0);
        $display("T2 done");
        for (k = 1; k < 4; k = k + 1) begin
            wr(`IPF_OFF_CTRL, 32'h4 | (k << 4), `IPF_RESP_OKAY);
            pk(ids[8 * k - 1 -: 8], sa, da, 7'h28, 1'b1);
            pk(ids[8 * k - 1 -: 8] ^ 8'h80, sa, da, 7'h28, 1'b0);
        end
        wr(`IPF_OFF_NHNUM, 32'h2F, `IPF_RESP_OKAY);
        wr(`IPF_OFF_CTRL, 32'h4, `IPF_RESP_OKAY);
        pk(8'h2F, sa, da, 7'h28, 1'b1);
        wr(`IPF_OFF_CTRL, 32'h14, `IPF_RESP_OKAY);
        pk(8'h2F, sa, da, 7'h28, 1'b0);
        $display("T3 done");
        wr(`IPF_OFF_CTRL, 32'h17, `IPF_RESP_OKAY);
        pk(8'h11, sa, da, 7'h28, 1'b1);
        pk(8'h06, sa, da, 7'h28, 1'b0);
        rd(`IPF_OFF_CTRL, 32'h17, `IPF_RESP_OKAY);
        rd(`IPF_OFF_STAT, 32'h2, `IPF_RESP_OKAY);
        rd(8'hFC, 32'h0, `IPF_RESP_SLVERR);
        wr(8'hFC, 32'hFF, `IPF_RESP_SLVERR);
        wr(`IPF_OFF_PASSCNT, 32'hFF, `IPF_RESP_OKAY);
        rd(`IPF_OFF_PASSCNT, ep[31:0], `IPF_RESP_OKAY);
        rd(`IPF_OFF_BLKCNT, eb[31:0], `IPF_RESP_OKAY);
        wstrb <= 4'h2;
        wr(`IPF_OFF_DSTADDR, 32'hFFFFFFFF, `IPF_RESP_OKAY);
        rd(`IPF_OFF_DSTADDR, 32'hFE80FF00, `IPF_RESP_OKAY);
        $display("T4 done");
        test_done;
    end
endmodule
